/* File: rtl/pin_six_pkg.sv */
/*
  Constants, field layout and carrier types for the pin six output multiplexer.
  Assumes one 250 MHz clock domain and source signals produced on that clock.
*/
// Functional notes
// - source field bits 4:2 picks source
// - receive source: selection 000 forwards remote pin0
// - receive source: 100 lock, 101 pass
// - receive source: 110 frame valid, 111 line valid
// - device status 000 drives software value bit
// - device status 001: OR of enabled locks
// - device status 010: AND of enabled locks
// - device status 011: AND of enabled passes
// - device status 100 frame sync; 101-111 reserved
// - transmit source: 000 AND, 001 OR of pass
// - transmit source: 010 frame valid, 011 line valid
// - transmit source: 100 synchronized, 101 interrupt, 110-111 reserved
// - bit 1 holds software level for pin
// - control at index 0x16, reset 0x00, bit0 enables
package pin_six_pkg;

  localparam int          NUM_RX_PORTS    = 4;
  localparam int          NUM_TX_PORTS    = 2;
  localparam int          NUM_REMOTE_PINS = 4;

  localparam int          AXI_ADDR_W      = 8;
  localparam int          AXI_DATA_W      = 32;
  localparam int          CTL_W           = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0]  CTL_INDEX       = 8'h16;
  localparam logic [7:0]  PIN_STATE_INDEX = 8'h20;
  localparam logic [7:0]  CTL_ADDR        = 8'(CTL_INDEX * 4);
  localparam logic [7:0]  PIN_STATE_ADDR  = 8'(PIN_STATE_INDEX * 4);
  localparam logic [7:0]  CTL_RESET       = 8'h00;

  localparam int          EN_BIT          = 0;
  localparam int          VAL_BIT         = 1;
  localparam int          SRC_LSB         = 2;
  localparam int          SRC_MSB         = 4;
  localparam int          SEL_LSB         = 5;
  localparam int          SEL_MSB         = 7;

  localparam logic [2:0]  SRC_DEVICE      = 3'h4;
  localparam logic [2:0]  SRC_RESERVED    = 3'h5;
  localparam logic [2:0]  SRC_TX0         = 3'h6;
  localparam logic [2:0]  SRC_TX1         = 3'h7;

  localparam logic [2:0]  RX_SEL_LOCK     = 3'h4;
  localparam logic [2:0]  RX_SEL_PASS     = 3'h5;
  localparam logic [2:0]  RX_SEL_FRAME    = 3'h6;
  localparam logic [2:0]  RX_SEL_LINE     = 3'h7;

  localparam logic [2:0]  DEV_SEL_VALUE   = 3'h0;
  localparam logic [2:0]  DEV_SEL_LOCK_OR = 3'h1;
  localparam logic [2:0]  DEV_SEL_LOCK_AND = 3'h2;
  localparam logic [2:0]  DEV_SEL_PASS_AND = 3'h3;
  localparam logic [2:0]  DEV_SEL_FSYNC   = 3'h4;

  localparam logic [2:0]  TX_SEL_PASS_AND = 3'h0;
  localparam logic [2:0]  TX_SEL_PASS_OR  = 3'h1;
  localparam logic [2:0]  TX_SEL_FRAME    = 3'h2;
  localparam logic [2:0]  TX_SEL_LINE     = 3'h3;
  localparam logic [2:0]  TX_SEL_SYNC     = 3'h4;
  localparam logic [2:0]  TX_SEL_IRQ      = 3'h5;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic                       lock;
    logic                       pass;
    logic                       frame_valid;
    logic                       line_valid;
    logic [NUM_REMOTE_PINS-1:0] remote_pins;
  } rx_port_status_s;

  typedef struct packed {
    logic [NUM_RX_PORTS-1:0]    feed_map;
    logic                       frame_valid;
    logic                       line_valid;
    logic                       synchronized;
    logic                       interrupt;
  } tx_port_status_s;

endpackage

/* File: rtl/rx_port_signal_mux.sv */
/*
  Picks one signal of a receive port by the selection code.
  Assumes the status bundle is on the same clock as the caller.
*/
module rx_port_signal_mux
  import pin_six_pkg::*;
(
  input  wire logic [2:0]      sel_i,
  input  rx_port_status_s      status_i,
  output logic                 bit_o
);

  always_comb begin
    case (sel_i)
      RX_SEL_LOCK:  bit_o = status_i.lock;
      RX_SEL_PASS:  bit_o = status_i.pass;
      RX_SEL_FRAME: bit_o = status_i.frame_valid;
      RX_SEL_LINE:  bit_o = status_i.line_valid;
      // codes 000-011 forward remote pins 0-3
      default:      bit_o = status_i.remote_pins[sel_i[1:0]];
    endcase
  end

endmodule

/* File: rtl/port_group_reduce.sv */
/*
  OR and AND of status bits over a mask of ports.
  Assumes mask and bits come from the same clock domain.
*/
module port_group_reduce #(
  parameter int WIDTH = 4
) (
  input  wire logic [WIDTH-1:0] mask_i,
  input  wire logic [WIDTH-1:0] bits_i,
  output logic                  any_o,
  output logic                  all_o
);

  always_comb begin
    any_o = |(bits_i & mask_i);
    // an empty mask reads as not all, so a pin never claims lock with no ports
    all_o = (|mask_i) && (&(bits_i | ~mask_i));
  end

endmodule

/* File: rtl/pin_six_output_mux.sv */
/*
  Control register and output multiplexer for auxiliary pin six, with an
  AXI4-Lite slave. Assumes all source signals are synchronous to clk_i; the
  bus must not be used while ce_i is low, since that freezes the slave too.
*/
module pin_six_output_mux
  import pin_six_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    ce_i,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                    s_axi_awvalid_i,
  output logic                         s_axi_awready_o,
  input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata_i,
  input  wire logic [3:0]              s_axi_wstrb_i,
  input  wire logic                    s_axi_wvalid_i,
  output logic                         s_axi_wready_o,
  output logic [1:0]                   s_axi_bresp_o,
  output logic                         s_axi_bvalid_o,
  input  wire logic                    s_axi_bready_i,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                    s_axi_arvalid_i,
  output logic                         s_axi_arready_o,
  output logic [AXI_DATA_W-1:0]        s_axi_rdata_o,
  output logic [1:0]                   s_axi_rresp_o,
  output logic                         s_axi_rvalid_o,
  input  wire logic                    s_axi_rready_i,
  input  rx_port_status_s [NUM_RX_PORTS-1:0] rx_status_i,
  input  wire logic [NUM_RX_PORTS-1:0] rx_port_enable_i,
  input  tx_port_status_s [NUM_TX_PORTS-1:0] tx_status_i,
  input  wire logic                    frame_sync_pulse_i,
  output logic                         aux_pin_six_o,
  output logic                         aux_pin_six_oe_o
);

  logic [CTL_W-1:0]        ctl_reg, ctl_next;
  logic                    aw_have_reg, aw_have_next;
  logic [AXI_ADDR_W-1:0]   aw_addr_reg, aw_addr_next;
  logic                    w_have_reg, w_have_next;
  logic [AXI_DATA_W-1:0]   w_data_reg, w_data_next;
  logic [3:0]              w_strb_reg, w_strb_next;
  logic                    awready_reg, awready_next;
  logic                    wready_reg, wready_next;
  logic                    bvalid_reg, bvalid_next;
  logic [1:0]              bresp_reg, bresp_next;
  logic                    arready_reg, arready_next;
  logic                    rvalid_reg, rvalid_next;
  logic [1:0]              rresp_reg, rresp_next;
  logic [AXI_DATA_W-1:0]   rdata_reg, rdata_next;
  logic                    pin_out_reg, pin_out_next;
  logic                    pin_oe_reg, pin_oe_next;

  logic [2:0]              src;
  logic [2:0]              sel;
  logic [NUM_RX_PORTS-1:0] rx_bit;
  logic [NUM_RX_PORTS-1:0] lock_vec;
  logic [NUM_RX_PORTS-1:0] pass_vec;
  logic                    dev_lock_any;
  logic                    dev_lock_all;
  logic                    dev_pass_any;
  logic                    dev_pass_all;
  logic [NUM_TX_PORTS-1:0] tx_pass_any;
  logic [NUM_TX_PORTS-1:0] tx_pass_all;
  logic                    mux_bit;
  tx_port_status_s         tx_sel;

  assign src    = ctl_reg[SRC_MSB:SRC_LSB];
  assign sel    = ctl_reg[SEL_MSB:SEL_LSB];
  assign tx_sel = tx_status_i[src[0]];

  genvar g;
  generate
    for (g = 0; g < NUM_RX_PORTS; g++) begin : g_rx
      assign lock_vec[g] = rx_status_i[g].lock;
      assign pass_vec[g] = rx_status_i[g].pass;
      rx_port_signal_mux u_rx_mux (
        .sel_i    (sel),
        .status_i (rx_status_i[g]),
        .bit_o    (rx_bit[g])
      );
    end
    for (g = 0; g < NUM_TX_PORTS; g++) begin : g_tx
      port_group_reduce #(.WIDTH(NUM_RX_PORTS)) u_tx_pass (
        .mask_i (tx_status_i[g].feed_map),
        .bits_i (pass_vec),
        .any_o  (tx_pass_any[g]),
        .all_o  (tx_pass_all[g])
      );
    end
  endgenerate

  port_group_reduce #(.WIDTH(NUM_RX_PORTS)) u_dev_lock (
    .mask_i (rx_port_enable_i),
    .bits_i (lock_vec),
    .any_o  (dev_lock_any),
    .all_o  (dev_lock_all)
  );

  port_group_reduce #(.WIDTH(NUM_RX_PORTS)) u_dev_pass (
    .mask_i (rx_port_enable_i),
    .bits_i (pass_vec),
    .any_o  (dev_pass_any),
    .all_o  (dev_pass_all)
  );

  // output multiplexer; reserved codes give a constant low
  always_comb begin
    mux_bit = 1'b0;
    if (src[2] == 1'b0) begin
      mux_bit = rx_bit[src[1:0]];
    end else if (src == SRC_DEVICE) begin
      case (sel)
        DEV_SEL_VALUE:    mux_bit = ctl_reg[VAL_BIT];
        DEV_SEL_LOCK_OR:  mux_bit = dev_lock_any;
        DEV_SEL_LOCK_AND: mux_bit = dev_lock_all;
        DEV_SEL_PASS_AND: mux_bit = dev_pass_all;
        DEV_SEL_FSYNC:    mux_bit = frame_sync_pulse_i;
        default:          mux_bit = 1'b0;
      endcase
    end else if (src != SRC_RESERVED) begin
      case (sel)
        TX_SEL_PASS_AND: mux_bit = tx_pass_all[src[0]];
        TX_SEL_PASS_OR:  mux_bit = tx_pass_any[src[0]];
        TX_SEL_FRAME:    mux_bit = tx_sel.frame_valid;
        TX_SEL_LINE:     mux_bit = tx_sel.line_valid;
        TX_SEL_SYNC:     mux_bit = tx_sel.synchronized;
        TX_SEL_IRQ:      mux_bit = tx_sel.interrupt;
        default:         mux_bit = 1'b0;
      endcase
    end
  end

  // pin is registered so it never glitches on a source change mid-cycle
  always_comb begin
    pin_oe_next  = ctl_reg[EN_BIT];
    pin_out_next = ctl_reg[EN_BIT] ? mux_bit : 1'b0;
  end

  // write channel: address and data taken in either order, answered together
  always_comb begin
    ctl_next     = ctl_reg;
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next  = w_have_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid_i && awready_reg) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_reg) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata_i;
      w_strb_next = s_axi_wstrb_i;
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      if ({aw_addr_reg[AXI_ADDR_W-1:2], 2'b00} == CTL_ADDR) begin
        bresp_next = RESP_OKAY;
        if (w_strb_reg[0]) begin
          ctl_next = w_data_reg[CTL_W-1:0];
        end
      end else if ({aw_addr_reg[AXI_ADDR_W-1:2], 2'b00} == PIN_STATE_ADDR) begin
        bresp_next = RESP_OKAY;
      end else begin
        bresp_next = RESP_SLVERR;
      end
    end
    awready_next = !aw_have_next;
    wready_next  = !w_have_next;
  end

  // read channel: one read at a time, answered one cycle after the address
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid_i && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = RESP_OKAY;
      if ({s_axi_araddr_i[AXI_ADDR_W-1:2], 2'b00} == CTL_ADDR) begin
        rdata_next = {{(AXI_DATA_W-CTL_W){1'b0}}, ctl_reg};
      end else if ({s_axi_araddr_i[AXI_ADDR_W-1:2], 2'b00} == PIN_STATE_ADDR) begin
        rdata_next = {{(AXI_DATA_W-2){1'b0}}, pin_oe_reg, pin_out_reg};
      end else begin
        rdata_next = {AXI_DATA_W{1'b0}};
        rresp_next = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctl_reg     <= CTL_RESET;
      aw_have_reg <= 1'b0;
      aw_addr_reg <= {AXI_ADDR_W{1'b0}};
      w_have_reg  <= 1'b0;
      w_data_reg  <= {AXI_DATA_W{1'b0}};
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= {AXI_DATA_W{1'b0}};
      pin_out_reg <= 1'b0;
      pin_oe_reg  <= 1'b0;
    end else if (ce_i) begin
      ctl_reg     <= ctl_next;
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg  <= w_have_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  assign s_axi_awready_o  = awready_reg;
  assign s_axi_wready_o   = wready_reg;
  assign s_axi_bvalid_o   = bvalid_reg;
  assign s_axi_bresp_o    = bresp_reg;
  assign s_axi_arready_o  = arready_reg;
  assign s_axi_rvalid_o   = rvalid_reg;
  assign s_axi_rresp_o    = rresp_reg;
  assign s_axi_rdata_o    = rdata_reg;
  assign aux_pin_six_o    = pin_out_reg;
  assign aux_pin_six_oe_o = pin_oe_reg;

  // independent reference values for checking
  wire logic chk_live         = ce_i && ctl_reg[EN_BIT];
  wire logic chk_rx_remote0   = rx_status_i[src[1:0]].remote_pins[0];
  wire logic chk_rx_lock      = rx_status_i[src[1:0]].lock;
  wire logic chk_rx_frame     = rx_status_i[src[1:0]].frame_valid;
  wire logic chk_dev_or       = |(lock_vec & rx_port_enable_i);
  wire logic chk_dev_and      = (rx_port_enable_i != 4'h0) &&
                                ((lock_vec & rx_port_enable_i) == rx_port_enable_i);
  wire logic chk_dev_pass_and = (rx_port_enable_i != 4'h0) &&
                                ((pass_vec & rx_port_enable_i) == rx_port_enable_i);
  wire logic chk_tx_and       = (tx_sel.feed_map != 4'h0) &&
                                ((pass_vec & tx_sel.feed_map) == tx_sel.feed_map);

  property p_reset_clear;
    @(posedge clk_i) !reset_n_i |=> (ctl_reg == CTL_RESET) && !aux_pin_six_oe_o && !aux_pin_six_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("control not clear after reset");
  property p_disabled_quiet;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && !ctl_reg[EN_BIT]) |=> !aux_pin_six_oe_o && !aux_pin_six_o;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("pin driven while disabled");
  property p_rx_remote0;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && !src[2] && sel == 3'h0) |=> aux_pin_six_oe_o && (aux_pin_six_o == $past(chk_rx_remote0));
  endproperty
  a_rx_remote0: assert property (p_rx_remote0) else $error("remote pin 0 not forwarded");
  property p_rx_lock;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && !src[2] && sel == RX_SEL_LOCK) |=> aux_pin_six_o == $past(chk_rx_lock);
  endproperty
  a_rx_lock: assert property (p_rx_lock) else $error("receive lock not on pin");
  property p_rx_frame;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && !src[2] && sel == RX_SEL_FRAME) |=> aux_pin_six_o == $past(chk_rx_frame);
  endproperty
  a_rx_frame: assert property (p_rx_frame) else $error("receive frame valid not on pin");
  property p_dev_value;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && src == SRC_DEVICE && sel == DEV_SEL_VALUE) |=> aux_pin_six_o == $past(ctl_reg[VAL_BIT]);
  endproperty
  a_dev_value: assert property (p_dev_value) else $error("value bit not on pin");
  property p_dev_or;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && src == SRC_DEVICE && sel == DEV_SEL_LOCK_OR) |=> aux_pin_six_o == $past(chk_dev_or);
  endproperty
  a_dev_or: assert property (p_dev_or) else $error("lock OR wrong");
  property p_dev_and;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && src == SRC_DEVICE && sel == DEV_SEL_LOCK_AND) |=> aux_pin_six_o == $past(chk_dev_and);
  endproperty
  a_dev_and: assert property (p_dev_and) else $error("lock AND wrong");
  property p_dev_pass;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && src == SRC_DEVICE && sel == DEV_SEL_PASS_AND) |=> aux_pin_six_o == $past(chk_dev_pass_and);
  endproperty
  a_dev_pass: assert property (p_dev_pass) else $error("pass AND wrong");
  property p_dev_reserved;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && src == SRC_DEVICE && sel > DEV_SEL_FSYNC) |=> !aux_pin_six_o;
  endproperty
  a_dev_reserved: assert property (p_dev_reserved) else $error("reserved status code not low");
  property p_tx_and;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && src[2:1] == 2'b11 && sel == TX_SEL_PASS_AND) |=> aux_pin_six_o == $past(chk_tx_and);
  endproperty
  a_tx_and: assert property (p_tx_and) else $error("transmit pass AND wrong");
  property p_src_reserved;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chk_live && src == SRC_RESERVED) |=> aux_pin_six_oe_o && !aux_pin_six_o;
  endproperty
  a_src_reserved: assert property (p_src_reserved) else $error("reserved source not low");
  property p_write_answer;
    @(posedge clk_i) disable iff (!reset_n_i)
      (ce_i && aw_have_reg && w_have_reg && !bvalid_reg) |=> s_axi_bvalid_o && s_axi_awready_o;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");
  c_rx_lock: cover property (@(posedge clk_i) chk_live && src == 3'h2 && sel == RX_SEL_LOCK);
  c_fsync:   cover property (@(posedge clk_i) chk_live && src == SRC_DEVICE && sel == DEV_SEL_FSYNC);
  c_tx_irq:  cover property (@(posedge clk_i) chk_live && src == SRC_TX1 && sel == TX_SEL_IRQ);

endmodule

/* File: verif/pin_sampler.sv */
/*
  Board-level consumer of auxiliary pin six: resolves the net level.
  Assumes a pull-down on the net, so an undriven pin reads low.
*/
module pin_sampler (
  input  wire logic pin_i,
  input  wire logic oe_i,
  output logic      level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // the pull-down wins only while the device has released the pin
  assign level_o = oe_i ? pin_i : 1'b0;
endmodule

/* File: verif/tb.sv */
/*
  Self-checking bench for the pin six output multiplexer.
  Assumes AXI4-Lite timing as handed over and registered pin outputs.
*/
module tb
  import pin_six_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, reset_n_i = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0, en = '0;
  logic awready, wready, bvalid, arready, rvalid, pin, oe, level;
  logic fsync = 1'b0;
  logic ce = 1'b1;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  rx_port_status_s [NUM_RX_PORTS-1:0] rx = '0;
  tx_port_status_s [NUM_TX_PORTS-1:0] tx = '0;
  int error_cnt = 0;
  int samples_checked = 0;

  always #2 clk_i = ~clk_i;

  pin_six_output_mux u_pin_six_output_mux (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rx_status_i(rx),
    .rx_port_enable_i(en), .tx_status_i(tx), .frame_sync_pulse_i(fsync),
    .aux_pin_six_o(pin), .aux_pin_six_oe_o(oe));

  pin_sampler u_pin_sampler (.pin_i(pin), .oe_i(oe), .level_o(level));

  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // wide enough for a response code and a full data word together
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t value mismatch seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr <= a;
    awvalid <= 1;
    wdata <= v;
    wstrb <= s;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk_i);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!(bvalid && bready) && n < 64);
    r = bresp;
    bready <= 0;
    if (n >= 64) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk_i);
      n++;
      if (arvalid && arready) arvalid <= 0;
    end while (!(rvalid && rready) && n < 64);
    d = rdata;
    r = rresp;
    rready <= 0;
    if (n >= 64) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // expected pin level for one control value under the present sources
  function automatic logic exp_pin(input logic [7:0] c);
    logic [2:0] s, q;
    logic [3:0] lk, ps, m;
    s = c[4:2];
    q = c[7:5];
    for (int i = 0; i < 4; i++) begin
      lk[i] = rx[i].lock;
      ps[i] = rx[i].pass;
    end
    m = tx[s[0]].feed_map;
    if (!c[0]) return 1'b0;
    if (!s[2]) begin
      case (q)
        3'h4: return rx[s[1:0]].lock;
        3'h5: return rx[s[1:0]].pass;
        3'h6: return rx[s[1:0]].frame_valid;
        3'h7: return rx[s[1:0]].line_valid;
        default: return rx[s[1:0]].remote_pins[q[1:0]];
      endcase
    end
    if (s == 3'h4) begin
      case (q)
        3'h0: return c[1];
        3'h1: return |(lk & en);
        3'h2: return (en != 0) && ((lk & en) == en);
        3'h3: return (en != 0) && ((ps & en) == en);
        3'h4: return fsync;
        default: return 1'b0;
      endcase
    end
    if (s == 3'h5) return 1'b0;
    case (q)
      3'h0: return (m != 0) && ((ps & m) == m);
      3'h1: return |(ps & m);
      3'h2: return tx[s[0]].frame_valid;
      3'h3: return tx[s[0]].line_valid;
      3'h4: return tx[s[0]].synchronized;
      3'h5: return tx[s[0]].interrupt;
      default: return 1'b0;
    endcase
  endfunction

  task automatic t_reset();
    rd(CTL_ADDR);
    chk({r, d}, {RESP_OKAY, 24'h0, CTL_RESET});
    chk({oe, pin}, 2'h0);
  endtask

  task automatic t_refuse();
    wr(8'h04, 32'h0000_00FF, 4'hF);
    chk(r, RESP_SLVERR);
    rd(8'h04);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    wr(CTL_ADDR, 32'h0000_00FF, 4'h0);
    chk(r, RESP_OKAY);
    wr(PIN_STATE_ADDR, 32'h0000_0003, 4'hF);
    chk(r, RESP_OKAY);
    rd(PIN_STATE_ADDR);
    chk({r, d}, {RESP_OKAY, 32'h0});
    rd(CTL_ADDR);
    chk(d, {24'h0, CTL_RESET});
  endtask

  // every control value, then a source flip without a register write
  task automatic t_sweep(input logic [31:0] rp, input logic [15:0] tp, input logic [3:0] e);
    logic x;
    rx <= rp;
    tx <= tp;
    en <= e;
    fsync <= rp[0];
    for (int c = 0; c < 256; c++) begin
      wr(CTL_ADDR, 32'(c), 4'hF);
      chk(r, RESP_OKAY);
      @(posedge clk_i);
      x = exp_pin(8'(c));
      chk({oe, pin, level}, {c[0], x, x});
      rd(CTL_ADDR);
      chk(d, 32'(c));
      rd(PIN_STATE_ADDR);
      chk(d, {30'h0, c[0], x});
      rx <= ~rx;
      tx <= ~tx;
      fsync <= ~fsync;
      repeat (2) @(posedge clk_i);
      chk(level, exp_pin(8'(c)));
    end
  endtask

  // a low clock enable must freeze the pin; a mid-run reset must clear it again
  task automatic t_hold();
    fsync <= 1'b0;
    wr(CTL_ADDR, {24'h0, DEV_SEL_FSYNC, SRC_DEVICE, 2'b01}, 4'hF);
    chk(r, RESP_OKAY);
    @(posedge clk_i);
    chk({oe, pin}, 2'h2);
    ce <= 1'b0;
    fsync <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({oe, pin}, 2'h2);
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({oe, pin}, 2'h3);
    reset_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_refuse();
    t_sweep(32'hC3D2_E1F0, 16'h3FA5, 4'hF);
    t_sweep(32'h9A6B_5C4D, 16'hC35A, 4'h6);
    t_sweep(32'hFFFF_FFFF, 16'h0F0F, 4'h0);
    t_hold();
    tally_and_finish();
  end
endmodule
